/* include/clc_map.svh */
`ifndef CLC_MAP_SVH
`define CLC_MAP_SVH
// Operation
// - text address set loads counter, targets text ram; one-line range 00H..4FH
// - two-line mode: line one 00H..27H, line two 40H..67H
// - busy flag high while an operation runs; host waits for it low
// - status read gives busy on bit 7, counter on bits 6..0
// - text or glyph data access steps counter by 1 per entry direction
// - data write stores one byte into the selected ram
// - last address-set instruction fixes the ram the counter points into
// - first read without address set is invalid; later reads are correct
// - glyph address set loads counter and targets glyph ram
// - bias select high gives 1/4 bias, low gives 1/5
// - bias select ignored when both bias-source selects are high
// - oscillator trim acts only with the adjust strap high
// - symbol address set, extension table only, loads 4-bit address 00H..0FH
// - symbol address set targets symbol ram
// - symbol display bit turns symbol segments on or off
// - booster bit acts only with internal follower; high runs booster
// - six-bit contrast: upper two and lower four bits by separate instructions
// - follower bit acts only with internal follower; high switches it on
// - gain ratio writable only with internal follower configured
// - extension table select chooses the table for later instructions
// - step direction high increments address, low decrements
// - bus width low: each byte moves as two nibbles, high first

// bus map, byte addresses
`define CLC_OFF_INSTR 8'h00
`define CLC_OFF_DATA 8'h04

// address bounds
`define CLC_TEXT_MAX_1L 7'h4F
`define CLC_TEXT_L1_END 7'h27
`define CLC_TEXT_L2_BEG 7'h40
`define CLC_TEXT_L2_END 7'h67
`define CLC_SYM_MAX 7'h0F

// extension table opcodes, upper nibble
`define CLC_OP_BIAS 4'h1
`define CLC_OP_SYMADDR 4'h4
`define CLC_OP_POWER 4'h5
`define CLC_OP_FOLLOW 4'h6
`define CLC_OP_CONTRAST 4'h7

// reset values
`define CLC_AC_RST 7'h00
`define CLC_TRIM_RST 3'h0
`define CLC_GAIN_RST 3'h0
`define CLC_CONTRAST_RST 6'h00

// timing
`define CLC_CLK_PERIOD_PS 8000
`define CLC_EXEC_TIME_PS 26300000
`define CLC_EXEC_CYCLES ((`CLC_EXEC_TIME_PS + `CLC_CLK_PERIOD_PS - 1) / `CLC_CLK_PERIOD_PS)
`endif

/* include/clc_pkg.sv */
package clc_pkg;
   typedef enum logic [1:0] {
      CLC_TEXT,
      CLC_GLYPH,
      CLC_SYMBOL
   } clc_ram_sel_t;
endpackage : clc_pkg

/* hdl/clc_ram.sv */
`timescale 1ns/100ps
module clc_ram #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   // clock
   input wire logic ref_clk,
   // write side
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read side
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   generate
      if (AW < 1 || AW > 7 || DW < 1) begin : g_bad
         $error("clc_ram: unsupported geometry");
      end
   endgenerate

   // contents are display data, left unreset on purpose
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule : clc_ram

/* hdl/clc_top.sv */
`timescale 1ns/100ps
`include "clc_map.svh"
module clc_top #(
   parameter int EXEC_CYCLES = `CLC_EXEC_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // strap pins
   input wire logic osc_adjust_strap,
   input wire logic bias_source_sel_a,
   input wire logic bias_source_sel_b,
   // drive controls
   output logic bias_quarter,
   output logic [2:0] osc_trim_eff,
   output logic symbol_on,
   output logic booster_on,
   output logic follower_on,
   output logic [2:0] gain_ratio,
   output logic [5:0] contrast_code,
   // state
   output logic busy_flag_bit,
   output logic two_line,
   output clc_pkg::clc_ram_sel_t ram_target
);
   import clc_pkg::*;

   generate
      if (EXEC_CYCLES < 1 || EXEC_CYCLES > 4095) begin : g_bad
         $error("clc_top: EXEC_CYCLES out of range");
      end
   endgenerate

   // strap synchronisers: change counts once stages two and three agree
   logic [2:0] strap_s1;
   logic [2:0] strap_s2;
   logic [2:0] strap_s3;
   logic [2:0] strap;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strap_s1 <= 3'h0;
         strap_s2 <= 3'h0;
         strap_s3 <= 3'h0;
         strap <= 3'h0;
      end else begin
         strap_s1 <= {osc_adjust_strap, bias_source_sel_b, bias_source_sel_a};
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
         for (int i = 0; i < 3; i++) begin
            if (strap_s2[i] == strap_s3[i]) begin
               strap[i] <= strap_s3[i];
            end
         end
      end
   end

   logic ext_bias;
   logic internal_fol;
   assign ext_bias = strap[0] & strap[1];
   assign internal_fol = ~strap[0] & ~strap[1];

   // control state
   logic [6:0] addr_counter;
   logic ext_table_select;
   logic bus_width_sel;
   logic entry_inc;
   logic bias_select;
   logic [2:0] osc_trim;
   logic booster_en;
   logic follower_en;
   logic nib_phase;
   logic [3:0] nib_hi;
   logic [11:0] busy_cnt;
   logic fetch;
   logic [7:0] read_latch;

   // bus front end
   logic req;
   logic hit_instr;
   logic hit_data;
   logic wr_req;
   logic rd_ok;
   logic full8;
   logic [7:0] instr_holding;
   logic exec;
   logic exec_instr;
   logic exec_data;
   logic data_rd_done;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign hit_instr = wb_adr_i == `CLC_OFF_INSTR;
   assign hit_data = wb_adr_i == `CLC_OFF_DATA;
   // instructions landing while busy are dropped, the host must poll first
   assign wr_req = req & wb_we_i & wb_sel_i[0] & (hit_instr | hit_data) & ~busy_flag_bit;
   assign rd_ok = req & ~wb_we_i & (hit_instr | (hit_data & ~busy_flag_bit));
   assign full8 = bus_width_sel | nib_phase;
   assign instr_holding = bus_width_sel ? wb_dat_i[7:0] : {nib_hi, wb_dat_i[7:4]};
   assign exec = wr_req & full8;
   assign exec_instr = exec & hit_instr;
   assign exec_data = exec & hit_data;
   assign data_rd_done = rd_ok & hit_data & full8;

   // decode
   logic [3:0] op_hi;
   logic dec_text;
   logic dec_glyph;
   logic dec_func;
   logic dec_entry;
   logic dec_bias;
   logic dec_symaddr;
   logic dec_power;
   logic dec_follow;
   logic dec_contrast;
   logic addr_set;

   assign op_hi = instr_holding[7:4];
   assign dec_text = exec_instr & instr_holding[7];
   assign dec_glyph = exec_instr & ~ext_table_select & (instr_holding[7:6] == 2'b01);
   assign dec_func = exec_instr & (instr_holding[7:5] == 3'b001);
   assign dec_entry = exec_instr & (instr_holding[7:2] == 6'b000001);
   assign dec_bias = exec_instr & ext_table_select & (op_hi == `CLC_OP_BIAS);
   assign dec_symaddr = exec_instr & ext_table_select & (op_hi == `CLC_OP_SYMADDR);
   assign dec_power = exec_instr & ext_table_select & (op_hi == `CLC_OP_POWER);
   assign dec_follow = exec_instr & ext_table_select & (op_hi == `CLC_OP_FOLLOW);
   assign dec_contrast = exec_instr & ext_table_select & (op_hi == `CLC_OP_CONTRAST);
   assign addr_set = dec_text | dec_glyph | dec_symaddr;

   function automatic logic [6:0] step_addr(input clc_ram_sel_t s, input logic [6:0] a,
                                            input logic up, input logic two);
      logic [6:0] r;
      r = a;
      case (s)
         CLC_TEXT: begin
            if (two) begin
               if (up) begin
                  r = (a == `CLC_TEXT_L1_END) ? `CLC_TEXT_L2_BEG :
                      (a == `CLC_TEXT_L2_END) ? 7'h00 : a + 7'h01;
               end else begin
                  r = (a == 7'h00) ? `CLC_TEXT_L2_END :
                      (a == `CLC_TEXT_L2_BEG) ? `CLC_TEXT_L1_END : a - 7'h01;
               end
            end else begin
               if (up) begin
                  r = (a == `CLC_TEXT_MAX_1L) ? 7'h00 : a + 7'h01;
               end else begin
                  r = (a == 7'h00) ? `CLC_TEXT_MAX_1L : a - 7'h01;
               end
            end
         end
         CLC_GLYPH: r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
         CLC_SYMBOL: r = {3'h0, up ? a[3:0] + 4'h1 : a[3:0] - 4'h1};
         default: r = a;
      endcase
      return r;
   endfunction : step_addr

   // wishbone handshake and read data
   logic [7:0] rd_byte;
   logic [7:0] lane_byte;
   always_comb begin
      rd_byte = hit_instr ? {busy_flag_bit, addr_counter} : read_latch;
      if (bus_width_sel) begin
         lane_byte = rd_byte;
      end else if (nib_phase) begin
         lane_byte = {rd_byte[3:0], 4'h0};
      end else begin
         lane_byte = {rd_byte[7:4], 4'h0};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (rd_ok) begin
            wb_dat_o <= {24'h00_0000, lane_byte};
         end else if (req) begin
            // unmapped or busy data read answers zero
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // nibble pairing, shared by reads and writes
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         nib_phase <= 1'b0;
         nib_hi <= 4'h0;
      end else if (bus_width_sel | dec_func) begin
         nib_phase <= 1'b0;
      end else if (wr_req | rd_ok) begin
         nib_phase <= ~nib_phase;
         if (wr_req & ~nib_phase) begin
            nib_hi <= wb_dat_i[7:4];
         end
      end
   end

   // busy timer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         busy_cnt <= 12'h000;
         busy_flag_bit <= 1'b0;
      end else if (exec | data_rd_done) begin
         busy_cnt <= 12'(EXEC_CYCLES);
         busy_flag_bit <= 1'b1;
      end else if (busy_cnt != 12'h000) begin
         busy_cnt <= busy_cnt - 12'h001;
         busy_flag_bit <= (busy_cnt != 12'h001);
      end
   end

   // address counter and target ram
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_counter <= `CLC_AC_RST;
         ram_target <= CLC_TEXT;
      end else if (dec_text) begin
         addr_counter <= instr_holding[6:0];
         ram_target <= CLC_TEXT;
      end else if (dec_glyph) begin
         addr_counter <= {1'b0, instr_holding[5:0]};
         ram_target <= CLC_GLYPH;
      end else if (dec_symaddr) begin
         addr_counter <= {3'h0, instr_holding[3:0]};
         ram_target <= CLC_SYMBOL;
      end else if (exec_data | data_rd_done) begin
         addr_counter <= step_addr(ram_target, addr_counter, entry_inc, two_line);
      end
   end

   // mode bits from the normal table
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ext_table_select <= 1'b0;
         bus_width_sel <= 1'b1;
         two_line <= 1'b0;
         entry_inc <= 1'b1;
      end else if (dec_func) begin
         bus_width_sel <= instr_holding[4];
         two_line <= instr_holding[3];
         ext_table_select <= instr_holding[0];
      end else if (dec_entry) begin
         entry_inc <= instr_holding[1];
      end
   end

   // extension table settings
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bias_select <= 1'b0;
         osc_trim <= `CLC_TRIM_RST;
         symbol_on <= 1'b0;
         booster_en <= 1'b0;
         follower_en <= 1'b0;
         gain_ratio <= `CLC_GAIN_RST;
         contrast_code <= `CLC_CONTRAST_RST;
      end else begin
         if (dec_bias) begin
            bias_select <= instr_holding[3];
            osc_trim <= instr_holding[2:0];
         end
         if (dec_power) begin
            symbol_on <= instr_holding[3];
         end
         if (dec_power & internal_fol) begin
            booster_en <= instr_holding[2];
            contrast_code[5:4] <= instr_holding[1:0];
         end
         if (dec_follow & internal_fol) begin
            follower_en <= instr_holding[3];
            gain_ratio <= instr_holding[2:0];
         end
         if (dec_contrast & internal_fol) begin
            contrast_code[3:0] <= instr_holding[3:0];
         end
      end
   end

   // effective drive controls
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bias_quarter <= 1'b0;
         osc_trim_eff <= `CLC_TRIM_RST;
         booster_on <= 1'b0;
         follower_on <= 1'b0;
      end else begin
         bias_quarter <= bias_select & ~ext_bias;
         osc_trim_eff <= strap[2] ? osc_trim : `CLC_TRIM_RST;
         booster_on <= booster_en & internal_fol;
         follower_on <= follower_en & internal_fol;
      end
   end

   // ram storage
   logic [7:0] text_rd;
   logic [7:0] glyph_rd;
   logic [7:0] sym_rd;

   clc_ram #(.AW(7), .DW(8)) u_text_ram (
      .ref_clk(ref_clk),
      .we(exec_data & (ram_target == CLC_TEXT)),
      .waddr(addr_counter),
      .wdata(instr_holding),
      .raddr(addr_counter),
      .rdata(text_rd)
   );

   clc_ram #(.AW(6), .DW(8)) u_glyph_ram (
      .ref_clk(ref_clk),
      .we(exec_data & (ram_target == CLC_GLYPH)),
      .waddr(addr_counter[5:0]),
      .wdata(instr_holding),
      .raddr(addr_counter[5:0]),
      .rdata(glyph_rd)
   );

   clc_ram #(.AW(4), .DW(8)) u_symbol_seg_ram (
      .ref_clk(ref_clk),
      .we(exec_data & (ram_target == CLC_SYMBOL)),
      .waddr(addr_counter[3:0]),
      .wdata(instr_holding),
      .raddr(addr_counter[3:0]),
      .rdata(sym_rd)
   );

   // read latch: refilled only after address set or a read, so a read
   // without a prior address set hands back stale data
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fetch <= 1'b0;
         read_latch <= 8'h00;
      end else begin
         fetch <= addr_set | data_rd_done;
         if (fetch) begin
            case (ram_target)
               CLC_TEXT: read_latch <= text_rd;
               CLC_GLYPH: read_latch <= glyph_rd;
               CLC_SYMBOL: read_latch <= sym_rd;
               default: read_latch <= 8'h00;
            endcase
         end
      end
   end

   // checks
   property p_busy_set;
      @(posedge ref_clk) disable iff (!rstn)
      exec |=> busy_flag_bit ##1 busy_flag_bit;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not raised");

   property p_status;
      @(posedge ref_clk) disable iff (!rstn)
      (rd_ok && hit_instr && bus_width_sel) |=>
         wb_dat_o[7:0] == {$past(busy_flag_bit), $past(addr_counter)};
   endproperty
   a_status: assert property (p_status) else $error("status byte wrong");

   property p_text_set;
      @(posedge ref_clk) disable iff (!rstn)
      dec_text |=> (addr_counter == $past(instr_holding[6:0])) && (ram_target == CLC_TEXT);
   endproperty
   a_text_set: assert property (p_text_set) else $error("text address not loaded");

   property p_glyph_set;
      @(posedge ref_clk) disable iff (!rstn)
      dec_glyph |=> ram_target == CLC_GLYPH;
   endproperty
   a_glyph_set: assert property (p_glyph_set) else $error("glyph not targeted");

   property p_wrap_two_line;
      @(posedge ref_clk) disable iff (!rstn)
      (exec_data && ram_target == CLC_TEXT && two_line && entry_inc &&
       addr_counter == 7'h27) |=> addr_counter == 7'h40;
   endproperty
   a_wrap_two_line: assert property (p_wrap_two_line) else $error("line wrap wrong");

   property p_step_down;
      @(posedge ref_clk) disable iff (!rstn)
      (exec_data && ram_target == CLC_GLYPH && !entry_inc && addr_counter == 7'h10)
         |=> addr_counter == 7'h0F;
   endproperty
   a_step_down: assert property (p_step_down) else $error("decrement wrong");

   property p_sym_addr;
      @(posedge ref_clk) disable iff (!rstn)
      dec_symaddr |=> (addr_counter <= 7'h0F) && (ram_target == CLC_SYMBOL);
   endproperty
   a_sym_addr: assert property (p_sym_addr) else $error("symbol address wrong");

   property p_ext_bias;
      @(posedge ref_clk) disable iff (!rstn)
      ext_bias |=> !bias_quarter;
   endproperty
   a_ext_bias: assert property (p_ext_bias) else $error("bias not ignored");

   property p_booster_lock;
      @(posedge ref_clk) disable iff (!rstn)
      (dec_power && !internal_fol) |=> $stable(booster_en) && $stable(contrast_code);
   endproperty
   a_booster_lock: assert property (p_booster_lock) else $error("locked write took");

   property p_nibble_hold;
      @(posedge ref_clk) disable iff (!rstn)
      (wr_req && !bus_width_sel && !nib_phase) |=> !busy_flag_bit && nib_phase;
   endproperty
   a_nibble_hold: assert property (p_nibble_hold) else $error("half byte executed");
endmodule : clc_top

/* testbench/clc_host.sv */
`timescale 1ns/100ps
module clc_host (
   // clock
   input wire logic ref_clk,
   // wishbone master side
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i
);
   int hangs = 0;
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'hFF;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h00000000;
   end
   // held until ack is sampled; released lines show inverted data, not the last value
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
         output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hF;
      wb_dat_o <= {24'h000000, wd};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_i !== 1'b1 && n < 64);
      rd = wb_dat_i[7:0];
      if (n >= 64) hangs++;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_adr_o <= ~adr;
      wb_dat_o <= ~{24'h000000, wd};
   endtask : bus
endmodule : clc_host

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`include "clc_map.svh"
module tb_top;
   import clc_pkg::*;
   logic ref_clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat;
   logic strap, sel_a, sel_b;
   logic bias_quarter, symbol_on, booster_on, follower_on, busy_flag_bit, two_line;
   logic [2:0] osc_trim_eff, gain_ratio;
   logic [5:0] contrast_code;
   clc_ram_sel_t ram_target;
   int failures = 0;
   int total_checks = 0;
   logic [6:0] ac;
   logic [7:0] rd, v, w;
   logic bs;
   logic two_mode = 1'b0;
   logic ext_mode = 1'b0;

   clc_host i_clc_host (.ref_clk(ref_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
      .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
      .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));
   clc_top #(.EXEC_CYCLES(8)) i_clc_top (.ref_clk(ref_clk), .rstn(rstn),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .osc_adjust_strap(strap), .bias_source_sel_a(sel_a), .bias_source_sel_b(sel_b),
      .bias_quarter(bias_quarter), .osc_trim_eff(osc_trim_eff), .symbol_on(symbol_on),
      .booster_on(booster_on), .follower_on(follower_on), .gain_ratio(gain_ratio),
      .contrast_code(contrast_code), .busy_flag_bit(busy_flag_bit),
      .two_line(two_line), .ram_target(ram_target));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // counter walk per ram: glyph wraps in 6 bits, symbol in 4, text per line mode
   function automatic logic [6:0] step(input clc_ram_sel_t s, input logic [6:0] a,
                                       input logic up);
      logic [6:0] n;
      n = up ? a + 7'h01 : a - 7'h01;
      if (s == CLC_GLYPH) return {1'b0, n[5:0]};
      if (s == CLC_SYMBOL) return {3'h0, n[3:0]};
      if (!two_mode) return up ? ((a == `CLC_TEXT_MAX_1L) ? 7'h00 : n) :
                                 ((a == 7'h00) ? `CLC_TEXT_MAX_1L : n);
      if (up) return (n == 7'h28) ? `CLC_TEXT_L2_BEG : (n == 7'h68) ? 7'h00 : n;
      return (a == 7'h00) ? `CLC_TEXT_L2_END : (a == `CLC_TEXT_L2_BEG) ? `CLC_TEXT_L1_END : n;
   endfunction : step

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value: %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tally_and_finish();
      failures += i_clc_host.hangs;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         i_clc_host.bus(1'b0, `CLC_OFF_INSTR, 8'h00, rd);
         n++;
      end while (rd[7] !== 1'b0 && n < 40);
      check("busy_flag_bit", 16'h0000, 16'(rd[7]));
   endtask : wait_idle

   // status right after an instruction must still read busy
   task automatic instr(input logic [7:0] b);
      i_clc_host.bus(1'b1, `CLC_OFF_INSTR, b, rd);
      i_clc_host.bus(1'b0, `CLC_OFF_INSTR, 8'h00, rd);
      check("busy_flag_bit", 16'h0001, 16'(rd[7]));
      wait_idle();
   endtask : instr

   task automatic ram_rw(input logic [7:0] set, input logic [6:0] a, input logic up);
      logic [7:0] d;
      d = 8'($urandom);
      instr(set | {1'b0, a});
      check("addr_counter", 16'(a), 16'(rd[6:0]));
      i_clc_host.bus(1'b1, `CLC_OFF_DATA, d, rd);
      wait_idle();
      ac = step(set[7] ? CLC_TEXT : ext_mode ? CLC_SYMBOL : CLC_GLYPH, a, up);
      check("addr_counter", 16'(ac), 16'(rd[6:0]));
      instr(set | {1'b0, a});
      i_clc_host.bus(1'b0, `CLC_OFF_DATA, 8'h00, rd);
      check("ram data", 16'(d), 16'(rd));
      wait_idle();
   endtask : ram_rw

   task automatic settle(input string s);
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      $display("test %s done", s);
   endtask : settle

   initial begin
      rstn = 1'b0;
      strap = 1'b0;
      sel_a = 1'b0;
      sel_b = 1'b0;
      void'($urandom(32'hD69A));
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      settle("reset");
      check("drive reset", 16'h0000, {bias_quarter, osc_trim_eff, symbol_on, booster_on,
         follower_on, gain_ratio, contrast_code});
      check("state reset", 16'h0000, {busy_flag_bit, two_line, 14'(ram_target)});
      for (int i = 0; i < 3; i++)
         ram_rw(8'h80, (i == 0) ? 7'h00 : (i == 1) ? 7'h4F : 7'($urandom_range(78, 1)), 1'b1);
      instr(8'h38);
      two_mode = 1'b1;
      ram_rw(8'h80, 7'h27, 1'b1);
      ram_rw(8'h80, 7'h40, 1'b1);
      ram_rw(8'h80, 7'h67, 1'b1);
      check("two_line", 16'h0001, 16'(two_line));
      instr(8'h04);
      ram_rw(8'h80, {1'($urandom), 6'h00} | 7'($urandom_range(39, 0)), 1'b0);
      ram_rw(8'h40, 7'h10, 1'b0);
      instr(8'h06);
      ram_rw(8'h40, 7'($urandom_range(63, 1)), 1'b1);
      check("ram_target", 16'(CLC_GLYPH), 16'(ram_target));
      // data write while busy must be dropped, counter unchanged
      i_clc_host.bus(1'b1, `CLC_OFF_INSTR, 8'h85, rd);
      i_clc_host.bus(1'b1, `CLC_OFF_DATA, 8'hA5, rd);
      wait_idle();
      check("addr_counter", 16'h0005, 16'(rd[6:0]));
      i_clc_host.bus(1'b0, 8'h08, 8'h00, rd);
      check("unmapped read", 16'h0000, 16'(rd));
      settle("text and glyph");
      instr(8'h39);
      ext_mode = 1'b1;
      ram_rw(8'h40, 7'($urandom_range(15, 0)), 1'b1);
      check("ram_target", 16'(CLC_SYMBOL), 16'(ram_target));
      strap <= 1'b1;
      settle("symbol");
      for (int f = 0; f < 8; f++) begin
         bs = 1'($urandom);
         instr(8'h10 | {4'h0, bs, 3'(f)});
         @(negedge ref_clk);
         check("bias_quarter", 16'(bs), 16'(bias_quarter));
         check("osc_trim_eff", 16'(f), 16'(osc_trim_eff));
      end
      strap <= 1'b0;
      sel_a <= 1'b1;
      sel_b <= 1'b1;
      settle("bias and trim");
      check("osc_trim_eff", 16'h0000, 16'(osc_trim_eff));
      check("bias_quarter", 16'h0000, 16'(bias_quarter));
      sel_a <= 1'b0;
      sel_b <= 1'b0;
      settle("straps");
      v = 8'($urandom);
      w = 8'($urandom);
      instr(8'h50 | {4'h0, v[3:0]});
      instr(8'h60 | {4'h0, v[7:4]});
      instr(8'h70 | {4'h0, w[3:0]});
      @(negedge ref_clk);
      check("power", 16'({v[3], v[2], v[7], v[6:4]}), 16'({symbol_on, booster_on,
         follower_on, gain_ratio}));
      check("contrast_code", 16'({v[1:0], w[3:0]}), 16'(contrast_code));
      sel_a <= 1'b1;
      settle("internal follower");
      instr(8'h50 | {4'h0, w[7:4]});
      instr(8'h60 | {4'h0, ~v[7:4]});
      instr(8'h70 | {4'h0, ~w[3:0]});
      @(negedge ref_clk);
      check("power", 16'({w[7], 2'b00, v[6:4]}), 16'({symbol_on, booster_on,
         follower_on, gain_ratio}));
      check("contrast_code", 16'({v[1:0], w[3:0]}), 16'(contrast_code));
      settle("external follower");
      // four-bit port: the address set 0x95 goes as two nibbles
      i_clc_host.bus(1'b1, `CLC_OFF_INSTR, 8'h20, rd);
      repeat (20) @(posedge ref_clk);
      i_clc_host.bus(1'b1, `CLC_OFF_INSTR, 8'h90, rd);
      i_clc_host.bus(1'b1, `CLC_OFF_INSTR, 8'h50, rd);
      repeat (20) @(posedge ref_clk);
      i_clc_host.bus(1'b0, `CLC_OFF_INSTR, 8'h00, rd);
      check("status high nibble", 16'h0001, 16'(rd[7:4]));
      i_clc_host.bus(1'b0, `CLC_OFF_INSTR, 8'h00, rd);
      check("status low nibble", 16'h0005, 16'(rd[7:4]));
      settle("nibble");
      tally_and_finish();
   end

   initial begin
      #400000;
      failures++;
      tally_and_finish();
   end
endmodule : tb_top
